// [design/serial_shift_path_map.vh]
`ifndef SERIAL_SHIFT_PATH_MAP_VH
`define SERIAL_SHIFT_PATH_MAP_VH
`define ADDR_FORMAT 12'h000
`define ADDR_TX_DATA 12'h004
`define ADDR_RX_DATA 12'h008
`define ADDR_STATUS 12'h00C
`define ADDR_CONTROL 12'h010
`define ADDR_BAUD 12'h014
`define FMT_SYNC 7
`define FMT_CHR7 6
`define FMT_PAR_ON 5
`define FMT_ODD 4
`define FMT_STOP2 3
`define FMT_MP 2
`define FMT_CKS_HI 1
`define FMT_CKS_LO 0
`define ST_TX_BUFFER_EMPTY_FLAG 7
`define ST_RDRF 6
`define ST_ORER 5
`define ST_FER 4
`define ST_PER 3
`define ST_TEND 2
`define ST_MPB 1
`define ST_MPBT 0
`define CTL_TX_ALLOW 0
`define CTL_RX_ALLOW 1
`define CTL_STANDBY 2
`define RST_RX_DATA 8'h00
`define RST_TX_DATA 8'hFF
`define RST_FORMAT 8'h00
`define RST_STATUS 8'h84
`define RST_BAUD 8'hFF
`define OVERSAMPLE 16
`endif

// [design/serial_shift_path_and_format.v]
// Functional notes
// - receiver shifts bits in LSB first
// - full byte copied to receive buffer
// - shift registers hidden from software
// - receive buffer read only, reset zero
// - transmitter shifts out LSB first
// - empty shifter loads buffer and starts
// - no load while empty flag set
// - buffer writable during shifting, back-to-back
// - transmit buffer RW, resets to FF
// - format register RW, resets to zero
// - bit 7 selects async or sync
// - bit 6 selects 7 or 8 bits
// - 7-bit mode drops transmit MSB
// - bit 5 enables async parity
// - bit 4 selects odd parity
// - parity makes total ones even/odd
// - receiver checks parity when enabled
// - bit 3 selects one or two stops
// - receiver checks only first stop
// - bit 2 multiprocessor, overrides parity
// - bits 1:0 select prescaler
// - clearing empty flag starts transmit
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "serial_shift_path_map.vh"
module serial_shift_path_and_format (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // serial line
  input wire rxd,
  output reg txd,
  output reg sck_out
);
  reg [7:0] serial_format_control;
  reg [7:0] tx_data_buffer;
  reg [7:0] rx_data_buffer;
  reg [7:0] serial_status_flags;
  reg [7:0] control;
  reg [7:0] baud_div;
  reg [7:0] tx_shift_reg;
  reg [7:0] rx_shift_reg;
  reg rx_s1, rx_s2;
  wire standby = control[`CTL_STANDBY];
  wire sync_mode = serial_format_control[`FMT_SYNC];
  wire chr7 = serial_format_control[`FMT_CHR7] & ~sync_mode;
  wire mp_on = serial_format_control[`FMT_MP] & ~sync_mode;
  wire par_on = serial_format_control[`FMT_PAR_ON] & ~sync_mode & ~mp_on;
  wire odd_par = serial_format_control[`FMT_ODD];
  wire stop2 = serial_format_control[`FMT_STOP2] & ~sync_mode;
  wire tx_allow = control[`CTL_TX_ALLOW];
  wire rx_allow = control[`CTL_RX_ALLOW];
  wire [3:0] nbits = chr7 ? 4'h7 : 4'h8;
  // prescaler then bit-rate divider gives one oversample tick
  reg [5:0] pre_cnt;
  reg [7:0] brr_cnt;
  reg pre_max;
  always @* begin
    case (serial_format_control[`FMT_CKS_HI:`FMT_CKS_LO])
      2'h0: pre_max = 1'b1;
      2'h1: pre_max = (pre_cnt[1:0] == 2'h3);
      2'h2: pre_max = (pre_cnt[3:0] == 4'hF);
      default: pre_max = (pre_cnt == 6'h3F);
    endcase
  end
  wire brr_hit = pre_max && (brr_cnt == baud_div);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 6'h00;
      brr_cnt <= 8'h00;
    end else if (standby) begin
      pre_cnt <= 6'h00;
      brr_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_max ? 6'h00 : pre_cnt + 6'h01;
      if (pre_max)
        brr_cnt <= brr_hit ? 8'h00 : brr_cnt + 8'h01;
    end
  end
  // 16 oversample ticks per async bit, 2 per sync bit
  reg [3:0] tx_os;
  wire tx_tick = brr_hit && (sync_mode ? tx_os[0] : (tx_os == 4'hF));
  // apb
  wire setup = psel && !penable;
  wire wr = setup && pwrite;
  wire rd = setup && !pwrite;
  wire mapped = (paddr == `ADDR_FORMAT) || (paddr == `ADDR_TX_DATA) ||
    (paddr == `ADDR_RX_DATA) || (paddr == `ADDR_STATUS) ||
    (paddr == `ADDR_CONTROL) || (paddr == `ADDR_BAUD);
  reg [7:0] rd_val;
  always @* begin
    case (paddr)
      `ADDR_FORMAT: rd_val = serial_format_control;
      `ADDR_TX_DATA: rd_val = tx_data_buffer;
      `ADDR_RX_DATA: rd_val = rx_data_buffer;
      `ADDR_STATUS: rd_val = serial_status_flags;
      `ADDR_CONTROL: rd_val = control;
      `ADDR_BAUD: rd_val = baud_div;
      default: rd_val = 8'h00;
    endcase
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (rd)
        prdata <= {24'h000000, rd_val};
    end
  end
  // transmitter
  localparam TX_IDLE = 2'h0;
  localparam TX_START = 2'h1;
  localparam TX_DATA = 2'h2;
  localparam TX_TAIL = 2'h3;
  reg [1:0] tx_state;
  reg [3:0] tx_cnt;
  reg tx_par;
  reg [1:0] tail_cnt;
  reg [1:0] tail_len;
  wire tx_load_ok = tx_allow && !serial_status_flags[`ST_TX_BUFFER_EMPTY_FLAG];
  wire [7:0] tx_masked = chr7 ? {1'b0, tx_data_buffer[6:0]} : tx_data_buffer;
  wire load_now = (tx_state == TX_IDLE) && tx_load_ok && tx_tick;
  reg tx_done;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_shift_reg <= 8'h00;
      tx_cnt <= 4'h0;
      tx_par <= 1'b0;
      tail_cnt <= 2'h0;
      tail_len <= 2'h0;
      tx_os <= 4'h0;
      txd <= 1'b1;
      sck_out <= 1'b1;
      tx_done <= 1'b0;
    end else if (standby) begin
      tx_state <= TX_IDLE;
      tx_os <= 4'h0;
      txd <= 1'b1;
      sck_out <= 1'b1;
      tx_done <= 1'b0;
    end else begin
      tx_done <= 1'b0;
      if (brr_hit)
        tx_os <= tx_os + 4'h1;
      if (sync_mode && brr_hit && tx_state == TX_DATA)
        sck_out <= tx_os[0];
      else if (tx_state != TX_DATA)
        sck_out <= 1'b1;
      if (tx_tick) begin
        case (tx_state)
          TX_IDLE: begin
            txd <= 1'b1;
            if (tx_load_ok) begin
              tx_shift_reg <= tx_masked;
              tx_par <= (^tx_masked) ^ odd_par;
              tx_cnt <= 4'h0;
              tail_len <= {1'b0, par_on} + {1'b0, mp_on} + 2'h1 + {1'b0, stop2};
              if (sync_mode) begin
                txd <= tx_masked[0];
                tx_shift_reg <= {1'b0, tx_masked[7:1]};
                tx_cnt <= 4'h1;
                tx_state <= TX_DATA;
              end else
                tx_state <= TX_START;
            end
          end
          TX_START: begin
            txd <= 1'b0;
            tx_state <= TX_DATA;
          end
          TX_DATA: begin
            if (tx_cnt == nbits) begin
              tail_cnt <= 2'h0;
              if (sync_mode) begin
                tx_state <= TX_IDLE;
                tx_done <= 1'b1;
              end else begin
                txd <= par_on ? tx_par : (mp_on ? serial_status_flags[`ST_MPBT] : 1'b1);
                tx_state <= TX_TAIL;
              end
            end else begin
              txd <= tx_shift_reg[0];
              tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
              tx_cnt <= tx_cnt + 4'h1;
            end
          end
          default: begin
            tail_cnt <= tail_cnt + 2'h1;
            txd <= 1'b1;
            if (tail_cnt + 2'h1 == tail_len) begin
              tx_state <= TX_IDLE;
              tx_done <= 1'b1;
            end
          end
        endcase
      end
    end
  end
  // receiver, async oversampled; sync sampled on own clock edges
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
    end else begin
      rx_s1 <= rxd;
      rx_s2 <= rx_s1;
    end
  end
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_DATA = 2'h2;
  localparam RX_STOP = 2'h3;
  reg [1:0] rx_state;
  reg [3:0] rx_os;
  reg [3:0] rx_cnt;
  reg rx_phase;
  reg rx_done, rx_fer, rx_per, rx_mpb;
  reg [7:0] rx_byte;
  wire rx_extra = par_on | mp_on;
  wire sync_sample = sync_mode && brr_hit && tx_os[0] && tx_state == TX_DATA;
  wire mid = brr_hit && (rx_os == 4'h7);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= RX_IDLE;
      rx_os <= 4'h0;
      rx_cnt <= 4'h0;
      rx_phase <= 1'b0;
      rx_shift_reg <= 8'h00;
      rx_done <= 1'b0;
      rx_fer <= 1'b0;
      rx_per <= 1'b0;
      rx_mpb <= 1'b0;
      rx_byte <= 8'h00;
    end else if (standby || !rx_allow) begin
      rx_state <= RX_IDLE;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (brr_hit)
        rx_os <= rx_os + 4'h1;
      if (sync_mode) begin
        if (sync_sample) begin
          rx_shift_reg <= {rx_s2, rx_shift_reg[7:1]};
          rx_cnt <= rx_cnt + 4'h1;
          if (rx_cnt == 4'h7) begin
            rx_cnt <= 4'h0;
            rx_byte <= {rx_s2, rx_shift_reg[7:1]};
            rx_fer <= 1'b0;
            rx_per <= 1'b0;
            rx_done <= 1'b1;
          end
        end
      end else begin
        case (rx_state)
          RX_IDLE: begin
            rx_os <= 4'h0;
            if (!rx_s2)
              rx_state <= RX_START;
          end
          RX_START: begin
            if (mid) begin
              rx_cnt <= 4'h0;
              rx_phase <= 1'b0;
              rx_shift_reg <= 8'h00;
              rx_state <= rx_s2 ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (mid) begin
              if (rx_cnt == nbits) begin
                rx_phase <= 1'b1;
                rx_per <= par_on && ((^rx_shift_reg) ^ rx_s2 ^ odd_par);
                rx_mpb <= rx_s2;
                rx_state <= RX_STOP;
              end else begin
                if (chr7)
                  rx_shift_reg <= {1'b0, rx_s2, rx_shift_reg[6:1]};
                else
                  rx_shift_reg <= {rx_s2, rx_shift_reg[7:1]};
                rx_cnt <= rx_cnt + 4'h1;
                if (rx_cnt + 4'h1 == nbits && !rx_extra)
                  rx_state <= RX_STOP;
              end
            end
          end
          default: begin
            if (mid) begin
              if (!rx_phase)
                rx_per <= 1'b0;
              rx_fer <= !rx_s2;
              rx_byte <= rx_shift_reg;
              rx_done <= 1'b1;
              rx_state <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end
  // registers and status
  wire rx_store = rx_done && !(mp_on && control[7] && !rx_mpb);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_format_control <= `RST_FORMAT;
      tx_data_buffer <= `RST_TX_DATA;
      rx_data_buffer <= `RST_RX_DATA;
      serial_status_flags <= `RST_STATUS;
      control <= 8'h00;
      baud_div <= `RST_BAUD;
    end else begin
      if (wr && paddr == `ADDR_CONTROL)
        control <= pwdata[7:0];
      if (standby) begin
        serial_format_control <= `RST_FORMAT;
        tx_data_buffer <= `RST_TX_DATA;
        rx_data_buffer <= `RST_RX_DATA;
        serial_status_flags <= `RST_STATUS;
      end else begin
        if (wr && paddr == `ADDR_FORMAT)
          serial_format_control <= pwdata[7:0];
        if (wr && paddr == `ADDR_TX_DATA)
          tx_data_buffer <= pwdata[7:0];
        if (wr && paddr == `ADDR_BAUD)
          baud_div <= pwdata[7:0];
        if (rx_store)
          rx_data_buffer <= rx_byte;
        // flags clear by writing 0; hardware set wins
        // later statements below are the hardware sets,
        // so an event in the same cycle as a clear survives;
        // mp bit to send is the one plain read/write bit
        if (wr && paddr == `ADDR_STATUS)
          serial_status_flags <= serial_status_flags &
            {pwdata[7:1], 1'b1} | {7'h00, pwdata[0]} & 8'h01 |
            {7'h00, 1'b0};
        if (wr && paddr == `ADDR_STATUS)
          serial_status_flags[`ST_MPBT] <= pwdata[0];
        if (!tx_allow || load_now)
          serial_status_flags[`ST_TX_BUFFER_EMPTY_FLAG] <= 1'b1;
        if (load_now)
          serial_status_flags[`ST_TEND] <= 1'b0;
        if (tx_done && serial_status_flags[`ST_TX_BUFFER_EMPTY_FLAG])
          serial_status_flags[`ST_TEND] <= 1'b1;
        if (rx_store) begin
          if (serial_status_flags[`ST_RDRF])
            serial_status_flags[`ST_ORER] <= 1'b1;
          else
            serial_status_flags[`ST_RDRF] <= 1'b1;
          if (rx_fer)
            serial_status_flags[`ST_FER] <= 1'b1;
          if (rx_per)
            serial_status_flags[`ST_PER] <= 1'b1;
          serial_status_flags[`ST_MPB] <= rx_mpb;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [test/serial_shift_path_properties.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_shift_path_checker (
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // line side
  input wire logic rxd,
  input wire logic txd,
  input wire logic sck_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0] fmt;
  logic sb;
  wire logic su = psel && !penable;
  // shadow of the format register, held clear while standby stands
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) begin
      fmt <= 8'h00;
      sb <= 1'b0;
    end else begin
      if (su && pwrite && paddr == 12'h010) sb <= pwdata[2];
      if (sb) fmt <= 8'h00;
      else if (su && pwrite && paddr == 12'h000) fmt <= pwdata[7:0];
    end
  answer_next_a: assert property (su |=> pready && penable)
    else $error("setup not answered");
  ready_pulse_a: assert property (pready |-> penable ##1 !pready)
    else $error("ready misplaced");
  err_decode_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 12'h014))
    else $error("bad slave error");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  format_read_a: assert property (su && !pwrite && paddr == 12'h000 |=> prdata[7:0] == fmt)
    else $error("format readback wrong");
  start_len_a: assert property ($fell(txd) && !fmt[7] |-> !txd [*8])
    else $error("start bit too short");
  rdata_hold_a: assert property (!(su && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  idle_clock_a: assert property (!fmt[7] |-> sck_out)
    else $error("clock out moved in async mode");
  cover property ($fell(txd));
  cover property (pready && pslverr);
  cover property (su && !pwrite && paddr == 12'h008);
endmodule
bind serial_shift_path_and_format serial_shift_path_checker chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rxd(rxd),
  .txd(txd), .sck_out(sck_out));
`default_nettype wire

// [test/serial_far_end.sv]
`timescale 1ns/10ps
`default_nettype none
module serial_far_end (
  // line
  input wire logic pclk,
  input wire logic txd,
  output var logic rxd,
  // bit timing
  input wire logic [10:0] bclk,
  input wire logic [3:0] nbits,
  // captured frame
  output var logic [11:0] frame,
  output var logic got
);
  initial begin
    rxd = 1'b1;
    got = 1'b0;
  end
  // mid-cell sampling; last bit not waited out so back-to-back frames are caught
  always begin
    @(negedge txd);
    frame = 12'hFFF;
    repeat (bclk / 2) @(posedge pclk);
    for (int i = 0; i < nbits; i++) begin
      frame[i] = txd;
      if (i < nbits - 1) repeat (bclk) @(posedge pclk);
    end
    got = 1'b1;
    @(posedge pclk);
    got = 1'b0;
  end
  task automatic send(input logic [11:0] f);
    for (int i = 0; i < nbits; i++) begin
      rxd <= f[i];
      repeat (bclk) @(posedge pclk);
    end
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [test/test_serial_shift_path_and_format.sv]
`timescale 1ns/10ps
`default_nettype none
module test_serial_shift_path_and_format;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rxd, txd, sck_out, got;
  logic [11:0] paddr, frame;
  logic [31:0] pwdata, prdata, rd;
  logic [10:0] bclk;
  logic [3:0] nbits;
  logic [7:0] f, d, d2;
  logic [7:0] fm[7] = '{8'h00, 8'h40, 8'h20, 8'h30, 8'h68, 8'h3C, 8'h01};
  int error_cnt = 0, checks_done = 0, seed = 32'h4d4680cb;
  logic [32:0] rq[$];
  logic [11:0] tq[$];
  serial_shift_path_and_format dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd), .sck_out(sck_out));
  serial_far_end far (.pclk(pclk), .txd(txd), .rxd(rxd), .bclk(bclk), .nbits(nbits),
    .frame(frame), .got(got));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  function automatic logic [7:0] dv(input logic [7:0] f, x);
    return f[6] ? {1'b0, x[6:0]} : x;
  endfunction
  // start, data lsb first, parity or mp bit, stops high
  function automatic logic [11:0] mkf(input logic [7:0] f, x);
    logic [11:0] r;
    r = {3'h7, dv(f, x), 1'b0};
    if (f[6]) r[8] = 1'b1;
    if (f[2]) r[9 - f[6]] = 1'b0;
    else if (f[5]) r[9 - f[6]] = ^dv(f, x) ^ f[4];
    return r;
  endfunction
  task automatic cmp(input logic [32:0] e, a);
    checks_done++;
    if (a !== e) begin
      error_cnt++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic cmp_frame(input logic [11:0] e, a);
    cmp({21'h0, e}, {21'h0, a});
  endtask
  always @(posedge pclk)
    if (pready === 1'b1 && !pwrite && rq.size() > 0) cmp(rq.pop_front(), {pslverr, prdata});
  always @(posedge got)
    cmp_frame(tq.size() > 0 ? tq.pop_front() : 12'h000, frame);
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] dt);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      results;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    apb(1'b1, a, {24'h0, v});
  endtask
  task automatic rdx(input logic [11:0] a, input logic [32:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic poll(input int b, input logic v);
    int k;
    k = 0;
    do begin
      apb(1'b0, 12'h00C, 32'h0);
      k++;
    end while (rd[b] !== v && k < 400);
    cmp({32'h0, v}, {32'h0, rd[b]});
    if (rd[b] !== v) results;
  endtask
  task automatic results;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    bclk = 11'd16;
    nbits = 4'd10;
    presetn = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdx(12'h000, 33'h0);
    rdx(12'h004, 33'h0FF);
    wr(12'h008, 8'h5A);
    rdx(12'h008, 33'h0);
    rdx(12'h018, 33'h100000000);
    wr(12'h014, 8'h00);
    wr(12'h010, 8'h03);
    foreach (fm[i]) begin
      f = fm[i];
      bclk = 11'd16 << (2 * f[1:0]);
      nbits = 4'(10 - f[6] + (f[5] | f[2]) + f[3]);
      wr(12'h000, f);
      rdx(12'h000, {25'h0, f});
      d = 8'($random(seed));
      tq.push_back(mkf(f, d));
      wr(12'h004, d);
      wr(12'h00C, 8'h7A);
      poll(2, 1'b1);
      cmp(33'h0, 33'(tq.size()));
      d = 8'($random(seed));
      far.send(mkf(f, d));
      poll(6, 1'b1);
      rdx(12'h008, {25'h0, dv(f, d)});
      wr(12'h00C, 8'hBE);
    end
    bclk = 11'd16;
    nbits = 4'd11;
    wr(12'h000, 8'h20);
    far.send(mkf(8'h20, 8'h5A) ^ 12'h200);
    poll(3, 1'b1);
    nbits = 4'd10;
    wr(12'h000, 8'h00);
    d = 8'($random(seed));
    d2 = 8'($random(seed));
    tq.push_back(mkf(8'h00, d));
    tq.push_back(mkf(8'h00, d2));
    wr(12'h004, d);
    wr(12'h00C, 8'h7E);
    poll(7, 1'b1);
    wr(12'h004, d2);
    rdx(12'h004, {25'h0, d2});
    wr(12'h00C, 8'h7E);
    poll(2, 1'b1);
    cmp(33'h0, 33'(tq.size()));
    wr(12'h000, 8'h5A);
    wr(12'h004, 8'h12);
    wr(12'h010, 8'h04);
    rdx(12'h000, 33'h0);
    rdx(12'h004, 33'h0FF);
    rdx(12'h008, 33'h0);
    results;
  end
endmodule
`default_nettype wire
